// [core/ptb_defs.svh]
// Register offsets, field positions, reset values and codes of the timer bank.
// Assumes inclusion by bare name from the core module, the checker and the bench.
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH
`define PTB_OFF_PRESCALE 32'h5100_0000
`define PTB_OFF_DIVDMA 32'h5100_0004
`define PTB_OFF_CONTROL 32'h5100_0008
`define PTB_OFF_TIMER0 32'h5100_000C
`define PTB_TIMER_STRIDE 32'h0000_000C
`define PTB_SUB_RELOAD 32'h0000_0000
`define PTB_SUB_COMPARE 32'h0000_0004
`define PTB_SUB_OBSERVE 32'h0000_0008
`define PTB_RST_PRESCALE 32'h0000_0000
`define PTB_RST_DIVDMA 32'h0000_0000
`define PTB_RST_CONTROL 32'h0000_0000
`define PTB_PRE0_LSB 0
`define PTB_PRE1_LSB 8
`define PTB_DZLEN_LSB 16
`define PTB_DMA_LSB 20
`define PTB_DMA_NONE 4'h0
`define PTB_DMA_T0 4'h1
`define PTB_DMA_T4 4'h5
`define PTB_DZ_EN_BIT 4
`endif

// [core/ptb_pkg.sv]
// Types shared by the timer bank.
// Needs no include file; ptb_defs.svh is not used here.
package ptb_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ptb_req_t;
  typedef struct packed {
    logic start;
    logic update;
    logic invert;
    logic autoReload;
  } ptb_ctl_t;
  typedef enum logic [1:0] {
    PTB_IDLE,
    PTB_RUN,
    PTB_RELOAD
  } ptb_state_t;
endpackage : ptb_pkg

// [core/ptb_timer_bank.sv]
// Five 16-bit down-counting timers with double buffers, PWM and dead zone.
// Assumes a register master on a plain strobe port, synchronous to ref_clk.
//
// Operation
// (RULE1) At zero, copy reload and compare buffers into counter and compare.
// (RULE2) Raise a timer interrupt at each zero when enabled.
// (RULE3) Reload buffer reads the stored value; live count via observe.
// (RULE4) Reload at zero only with auto-reload; otherwise stop at zero.
// (RULE5) While manual update set, load counter and compare at once.
// (RULE6) Software writes buffers, sets update, then starts clearing update.
// (RULE7) Stopping a timer keeps its count, with no reload.
// (RULE8) Inverter change alters the output pin at once.
// (RULE9) Software should change inverter together with manual update.
// (RULE10) Counting starts within one timer tick after start.
// (RULE11) Output goes low to high when count equals compare.
// (RULE12) At zero hold reload in a temporary, load it next tick.
// (RULE13) Reload sets period, compare sets duty; inverter reverses it.
// (RULE14) Compare buffer writes affect only the next cycle.
// (RULE15) Stopped: output high when count at or below compare.
// (RULE16) One-shot: output stays high and timer halts after zero.
// (RULE17) Timer 0 gives output and complement; dead zone replaces both.
// (RULE18) Dead-zone outputs are never high at the same time.
// (RULE19) Eight-bit dead-zone length counts timer 0 ticks.
// (RULE20) DMA request held low until acknowledge, then released.
// (RULE21) DMA codes 1..5 pick timers 0..4 and mute only their interrupt.
// (RULE22) Tick is clock over prescaler plus one, then over divider.
// (RULE23) DMA selection is a 4-bit field resetting to no selection.
// (RULE24) Five timers, 16-bit counters; timer 4 has no pin.
`timescale 1ns/1ns
`include "ptb_defs.svh"
module ptb_timer_bank #(
  parameter int NTIMER = 5,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire ptb_pkg::ptb_req_t busReq,
  output logic [31:0] busRdata,
  // Timer interrupt enables and requests
  input wire logic [NTIMER-1:0] irqEnable,
  output logic [NTIMER-1:0] timerIrq,
  // DMA handshake
  output logic dma_request_low,
  input wire logic dmaAck,
  // PWM pins
  output logic ch0_pwm_output,
  output logic ch0_pwm_complement,
  output logic ch1_output_pin,
  output logic [1:0] pwmOutputHi
);
  initial
  begin
    if (NTIMER != 5 || CW != 16)
      $error("ptb_timer_bank serves five 16-bit timers only");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] prescale_r;
  logic [31:0] divDma_r;
  logic [31:0] control_r;
  logic [CW-1:0] reloadBuf_r [NTIMER];
  logic [CW-1:0] compareBuf_r [NTIMER];
  logic [CW-1:0] downCounter_r [NTIMER];
  logic [CW-1:0] compareReg_r [NTIMER];

  // Control bits of one timer; timer 4 has no inverter bit.
  function automatic ptb_pkg::ptb_ctl_t ctlOf(input logic [31:0] c,
                                              input int n);
    ptb_pkg::ptb_ctl_t v;
    int b;
    b = (n == 0) ? 0 : 4 * n + 4;
    v.start = c[b];
    v.update = c[b+1];
    v.invert = (n == 4) ? 1'b0 : c[b+2];
    v.autoReload = (n == 4) ? c[b+2] : c[b+3];
    return v;
  endfunction : ctlOf

  // Index of the timer that a buffer address names, or NTIMER if none.
  function automatic int timerOf(input logic [31:0] a);
    logic [31:0] d;
    d = a - `PTB_OFF_TIMER0;
    for (int i = 0; i < NTIMER; i++)
    begin
      if (a >= `PTB_OFF_TIMER0 && d / `PTB_TIMER_STRIDE == 32'(i))
        return i;
    end
    return NTIMER;
  endfunction : timerOf

  function automatic logic [31:0] subOf(input logic [31:0] a);
    return (a - `PTB_OFF_TIMER0) % `PTB_TIMER_STRIDE;
  endfunction : subOf

  int wrTimer;
  logic [31:0] wrSub;
  assign wrTimer = timerOf(busReq.addr);
  assign wrSub = subOf(busReq.addr);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // (RULE23) DMA field resets to none
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      prescale_r <= `PTB_RST_PRESCALE;
      divDma_r <= `PTB_RST_DIVDMA;
      control_r <= `PTB_RST_CONTROL;
    end
    else if (busReq.wr)
    begin
      if (busReq.addr == `PTB_OFF_PRESCALE)
        prescale_r <= {8'h00, busReq.wdata[23:0]};
      if (busReq.addr == `PTB_OFF_DIVDMA)
        divDma_r <= {8'h00, busReq.wdata[23:0]};
      if (busReq.addr == `PTB_OFF_CONTROL)
        control_r <= {9'h000, busReq.wdata[22:8], 3'b000, busReq.wdata[4:0]};
    end
  end

  // (RULE14) Buffers only; the cycle in progress is untouched
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NTIMER; i++)
    begin
      if (!reset_n)
      begin
        reloadBuf_r[i] <= '0;
        compareBuf_r[i] <= '0;
      end
      else if (busReq.wr && wrTimer == i)
      begin
        if (wrSub == `PTB_SUB_RELOAD)
          reloadBuf_r[i] <= busReq.wdata[CW-1:0];
        if (wrSub == `PTB_SUB_COMPARE && i != 4)
          compareBuf_r[i] <= busReq.wdata[CW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [31:0] rdNxt;
  always_comb
  begin
    rdNxt = 32'h0000_0000;
    if (busReq.addr == `PTB_OFF_PRESCALE)
      rdNxt = prescale_r;
    else if (busReq.addr == `PTB_OFF_DIVDMA)
      rdNxt = divDma_r;
    else if (busReq.addr == `PTB_OFF_CONTROL)
      rdNxt = control_r;
    else if (wrTimer < NTIMER)
    begin
      // (RULE3) Buffer reads stored value
      if (wrSub == `PTB_SUB_RELOAD)
        rdNxt = {16'h0000, reloadBuf_r[wrTimer]};
      else if (wrSub == `PTB_SUB_COMPARE)
        rdNxt = {16'h0000, compareBuf_r[wrTimer]};
      else if (wrSub == `PTB_SUB_OBSERVE)
        rdNxt = {16'h0000, downCounter_r[wrTimer]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      busRdata <= 32'h0000_0000;
    else if (busReq.rd)
      busRdata <= rdNxt;
    else
      busRdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------------
  // Prescalers and dividers
  // ----------------------------------------------------------------------
  logic [7:0] preCnt_r [2];
  logic [1:0] preTick;
  logic [3:0] divCnt_r [NTIMER];
  logic [NTIMER-1:0] tick;

  // (RULE22) Prescale then divide
  always_ff @(posedge ref_clk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!reset_n || preTick[p])
        preCnt_r[p] <= 8'h00;
      else
        preCnt_r[p] <= preCnt_r[p] + 8'h01;
    end
  end
  assign preTick[0] = preCnt_r[0] == prescale_r[`PTB_PRE0_LSB +: 8];
  assign preTick[1] = preCnt_r[1] == prescale_r[`PTB_PRE1_LSB +: 8];

  // Divider codes with bit 2 set count as 1/16 and bit 3 is ignored; no external tick input exists.
  genvar g;
  generate
    for (g = 0; g < NTIMER; g++)
    begin : gDiv
      logic [3:0] divMask;
      logic [1:0] sel;
      assign sel = divDma_r[4*g+2] ? 2'd3 : divDma_r[4*g +: 2];
      assign divMask = 4'((5'd2 << sel) - 5'd1);
      assign tick[g] = preTick[g < 2 ? 0 : 1] && (divCnt_r[g] == divMask);
      always_ff @(posedge ref_clk)
      begin
        if (!reset_n || tick[g])
          divCnt_r[g] <= 4'h0;
        else if (preTick[g < 2 ? 0 : 1])
          divCnt_r[g] <= divCnt_r[g] + 4'h1;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  ptb_pkg::ptb_state_t state_r [NTIMER];
  logic [CW-1:0] hold_r [NTIMER];
  logic [NTIMER-1:0] pwmLevel_r;
  logic [NTIMER-1:0] zeroEvt;
  logic [3:0] dmaSel;
  assign dmaSel = divDma_r[`PTB_DMA_LSB +: 4];

  generate
    for (g = 0; g < NTIMER; g++)
    begin : gTim
      ptb_pkg::ptb_ctl_t c;
      assign c = ctlOf(control_r, g);
      assign zeroEvt[g] = tick[g] && state_r[g] == ptb_pkg::PTB_RUN &&
                          c.start && downCounter_r[g] == '0;
      always_ff @(posedge ref_clk)
      begin
        if (!reset_n)
        begin
          state_r[g] <= ptb_pkg::PTB_IDLE;
          downCounter_r[g] <= '0;
          compareReg_r[g] <= '0;
          hold_r[g] <= '0;
          pwmLevel_r[g] <= 1'b0;
        end
        // (RULE5) Manual update loads at once
        else if (c.update)
        begin
          downCounter_r[g] <= reloadBuf_r[g];
          compareReg_r[g] <= compareBuf_r[g];
          // (RULE15) Stopped level follows the loaded count and compare
          pwmLevel_r[g] <= (reloadBuf_r[g] <= compareBuf_r[g]);
          state_r[g] <= ptb_pkg::PTB_IDLE;
        end
        // (RULE7) Stop keeps the count
        else if (!c.start)
          state_r[g] <= ptb_pkg::PTB_IDLE;
        else if (tick[g])
        begin
          case (state_r[g])
            // (RULE10) First tick after start already counts
            ptb_pkg::PTB_IDLE:
            begin
              if (downCounter_r[g] != '0)
              begin
                downCounter_r[g] <= downCounter_r[g] - CW'(1);
                if (downCounter_r[g] - CW'(1) == compareReg_r[g])
                  pwmLevel_r[g] <= 1'b1;
                state_r[g] <= ptb_pkg::PTB_RUN;
              end
            end
            ptb_pkg::PTB_RUN:
            begin
              if (downCounter_r[g] == '0)
              begin
                // (RULE1) Buffers into compare and temporary
                compareReg_r[g] <= compareBuf_r[g];
                hold_r[g] <= reloadBuf_r[g];
                // (RULE4) One-shot halts at zero
                if (c.autoReload)
                begin
                  // (RULE12) Temporary holds the reload
                  state_r[g] <= ptb_pkg::PTB_RELOAD;
                end
                else
                  state_r[g] <= ptb_pkg::PTB_IDLE;
              end
              else
              begin
                downCounter_r[g] <= downCounter_r[g] - CW'(1);
                // (RULE11) Rise on match
                if (downCounter_r[g] - CW'(1) == compareReg_r[g])
                  pwmLevel_r[g] <= 1'b1;
              end
            end
            ptb_pkg::PTB_RELOAD:
            begin
              // (RULE12) Load counter next tick
              downCounter_r[g] <= hold_r[g];
              pwmLevel_r[g] <= (hold_r[g] <= compareReg_r[g]);
              state_r[g] <= ptb_pkg::PTB_RUN;
            end
            default:
              state_r[g] <= ptb_pkg::PTB_IDLE;
          endcase
        end
      end
      // (RULE2) Interrupt at zero, muted for the DMA timer
      // (RULE21) Only the selected timer loses its interrupt
      assign timerIrq[g] = zeroEvt[g] && irqEnable[g] &&
                           dmaSel != 4'(g + 1);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output levels
  // ----------------------------------------------------------------------
  // (RULE15) Level follows count against compare; one-shot ends high
  // (RULE16) Reaching zero leaves the level high
  // (RULE13) Larger compare, longer high time
  // (RULE8) Inverter acts at once
  logic [3:0] pinLevel;
  always_comb
  begin
    ptb_pkg::ptb_ctl_t cv;
    cv = '0;
    pinLevel = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      cv = ctlOf(control_r, i);
      pinLevel[i] = pwmLevel_r[i] ^ cv.invert;
    end
  end

  // ----------------------------------------------------------------------
  // Dead zone
  // ----------------------------------------------------------------------
  // A change of level first drops both outputs, then the new side rises
  // only after the gap, so a zero-length gap still gives one clock apart.
  logic [7:0] dzCnt_r;
  logic dzLast_r;
  logic dzOut_r;
  logic dzComp_r;
  logic dzEn;
  assign dzEn = control_r[`PTB_DZ_EN_BIT];
  // (RULE19) Gap counted in timer 0 ticks
  // (RULE18) Never both high
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      dzCnt_r <= 8'h00;
      dzLast_r <= 1'b0;
      dzOut_r <= 1'b0;
      dzComp_r <= 1'b0;
    end
    else if (pinLevel[0] != dzLast_r)
    begin
      dzLast_r <= pinLevel[0];
      dzCnt_r <= prescale_r[`PTB_DZLEN_LSB +: 8];
      dzOut_r <= 1'b0;
      dzComp_r <= 1'b0;
    end
    else if (dzCnt_r != 8'h00)
    begin
      if (tick[0])
        dzCnt_r <= dzCnt_r - 8'h01;
    end
    else
    begin
      dzOut_r <= dzLast_r;
      dzComp_r <= !dzLast_r;
    end
  end

  // (RULE17) Complement and dead-zone routing
  // (RULE24) Timer 4 has no pin
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ch0_pwm_output <= 1'b0;
      ch0_pwm_complement <= 1'b1;
      ch1_output_pin <= 1'b0;
      pwmOutputHi <= 2'b00;
    end
    else
    begin
      ch0_pwm_output <= dzEn ? dzOut_r : pinLevel[0];
      ch0_pwm_complement <= dzEn ? dzComp_r : !pinLevel[0];
      ch1_output_pin <= dzEn ? dzComp_r : pinLevel[1];
      pwmOutputHi <= pinLevel[3:2];
    end
  end

  // ----------------------------------------------------------------------
  // DMA request
  // ----------------------------------------------------------------------
  logic dmaEvt;
  always_comb
  begin
    dmaEvt = 1'b0;
    for (int i = 0; i < NTIMER; i++)
      if (dmaSel == 4'(i + 1))
        dmaEvt = zeroEvt[i];
  end
  // (RULE20) Hold low until acknowledge; a new event wins
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      dma_request_low <= 1'b1;
    else if (dmaEvt)
      dma_request_low <= 1'b0;
    else if (dmaAck)
      dma_request_low <= 1'b1;
  end
endmodule : ptb_timer_bank

// [dv/ptb_timer_bank_monitor.sv]
// Port checker of the timer bank: bus, events, DMA and pin relations.
// Assumes it is bound into ptb_timer_bank with the defines on the path.
`timescale 1ns/1ns
`include "ptb_defs.svh"
module ptb_timer_bank_monitor #(
  parameter int NTIMER = 5,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire ptb_pkg::ptb_req_t busReq,
  input wire logic [31:0] busRdata,
  // Events
  input wire logic [NTIMER-1:0] irqEnable,
  input wire logic [NTIMER-1:0] timerIrq,
  input wire logic dma_request_low,
  input wire logic dmaAck,
  // Pins
  input wire logic ch0_pwm_output,
  input wire logic ch0_pwm_complement,
  input wire logic ch1_output_pin,
  input wire logic [1:0] pwmOutputHi
);
  // ----
  // Shadows
  // ----
  // The dead-zone enable is kept two deep so that the pin checks skip
  // the edges at which the output select is still switching.
  logic [23:0] cfg_r;
  logic [3:0] dmaSel_r;
  logic dzEn_r;
  logic dzOld_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cfg_r <= 24'h00_0000;
      dmaSel_r <= `PTB_DMA_NONE;
      dzEn_r <= 1'b0;
      dzOld_r <= 1'b0;
    end
    else
    begin
      dzOld_r <= dzEn_r;
      if (busReq.wr && busReq.addr == `PTB_OFF_PRESCALE)
        cfg_r <= busReq.wdata[23:0];
      if (busReq.wr && busReq.addr == `PTB_OFF_DIVDMA)
        dmaSel_r <= busReq.wdata[`PTB_DMA_LSB+:4];
      if (busReq.wr && busReq.addr == `PTB_OFF_CONTROL)
        dzEn_r <= busReq.wdata[`PTB_DZ_EN_BIT];
    end
  end
  sequence s_cfgRead;
    busReq.rd && busReq.addr == `PTB_OFF_PRESCALE;
  endsequence
  sequence s_dmaWait;
    !dma_request_low && !dmaAck;
  endsequence
  a_rdata_idle: assert property (
    !busReq.rd |=> busRdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_cfg_readback: assert property (
    s_cfgRead |=> busRdata[23:0] == cfg_r)
    else $error("prescale config read back wrong");
  a_irq_gated: assert property (
    timerIrq != '0 |-> (timerIrq & ~irqEnable) == '0)
    else $error("interrupt on a disabled timer");
  a_irq_pulse: assert property (
    timerIrq[0] |=> !timerIrq[0])
    else $error("timer 0 interrupt longer than a clock");
  a_dma_mute: assert property (
    dmaSel_r inside {[4'h1:4'h5]} |-> !timerIrq[dmaSel_r - 4'h1])
    else $error("interrupt from the DMA timer");
  a_dma_hold: assert property (
    s_dmaWait |=> !dma_request_low)
    else $error("DMA request dropped before acknowledge");
  a_dz_apart: assert property (
    dzEn_r && dzOld_r |-> !(ch0_pwm_output && ch1_output_pin))
    else $error("gapped outputs high together");
  a_comp_inverse: assert property (
    !dzEn_r && !dzOld_r |-> ch0_pwm_complement != ch0_pwm_output)
    else $error("timer 0 complement not inverse");
endmodule : ptb_timer_bank_monitor
bind ptb_timer_bank ptb_timer_bank_monitor #(.NTIMER(NTIMER), .CW(CW)) u_mon (
  .ref_clk, .reset_n, .busReq, .busRdata, .irqEnable, .timerIrq,
  .dma_request_low, .dmaAck, .ch0_pwm_output, .ch0_pwm_complement,
  .ch1_output_pin, .pwmOutputHi);

// [dv/ptb_dma_model.sv]
// DMA controller partner: acknowledges a held request after a delay.
// Assumes the request is active low and synchronous to ref_clk.
`timescale 1ns/1ns
module ptb_dma_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Handshake
  input wire logic dma_request_low,
  output logic dmaAck,
  // Bench control and status
  input wire logic [3:0] ackDelay,
  output int ackCount
);
  int waitCnt;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      dmaAck <= 1'b0;
      waitCnt <= 0;
      ackCount <= 0;
    end
    else if (dmaAck || dma_request_low)
    begin
      dmaAck <= 1'b0;
      waitCnt <= 0;
    end
    else if (waitCnt >= int'(ackDelay))
    begin
      dmaAck <= 1'b1;
      ackCount <= ackCount + 1;
    end
    else
      waitCnt <= waitCnt + 1;
  end
endmodule : ptb_dma_model

// [dv/ptb_timer_bank_tb_top.sv]
// Bench of the timer bank: register model, DMA partner, counted events.
// Assumes the core files, checker and partner are compiled before it.
`timescale 1ns/1ns
`include "ptb_defs.svh"
module ptb_timer_bank_tb_top;
  localparam logic [31:0] T0 = `PTB_OFF_TIMER0;
  localparam logic [31:0] CTL = `PTB_OFF_CONTROL;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  ptb_pkg::ptb_req_t busReq = '0;
  logic [4:0] irqEnable = 5'h1f;
  logic [3:0] ackDelay = 4'h0;
  logic [31:0] busRdata, got, obs;
  logic [4:0] timerIrq;
  logic dmaReqLow, dmaAck, out0, cmp0, out1;
  logic [1:0] hi23;
  logic last0 = 1'b0;
  logic [3:0] codes [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h1};
  logic [31:0] mdl [logic [31:0]];
  int num_errors = 0;
  int compares = 0;
  int irqCount = 0;
  int both = 0;
  int rise = 0;
  int ackCount, a0, r;
  always #5 ref_clk = ~ref_clk;
  ptb_timer_bank u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .busReq(busReq), .busRdata(busRdata), .irqEnable(irqEnable),
    .timerIrq(timerIrq), .dma_request_low(dmaReqLow), .dmaAck(dmaAck),
    .ch0_pwm_output(out0), .ch0_pwm_complement(cmp0),
    .ch1_output_pin(out1), .pwmOutputHi(hi23));
  ptb_dma_model u_dma (.ref_clk(ref_clk), .reset_n(reset_n),
    .dma_request_low(dmaReqLow), .dmaAck(dmaAck), .ackDelay(ackDelay),
    .ackCount(ackCount));
  // Counted at the falling edge, where every registered output is settled.
  always @(negedge ref_clk)
  begin
    irqCount += int'(timerIrq[0] === 1'b1);
    both += int'(out0 === 1'b1 && out1 === 1'b1);
    rise += int'(out0 === 1'b1 && last0 === 1'b0);
    last0 = out0;
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
  begin
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  end
  endtask : chk
  // A gap cycle follows each strobe so no signal is assigned twice at once.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
  begin
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
    mdl[a] = d;
    @(posedge ref_clk);
  end
  endtask : wr
  task automatic rd(input logic [31:0] a);
  begin
    busReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1 got = busRdata;
    @(posedge ref_clk);
  end
  endtask : rd
  task automatic rdchk(input logic [31:0] a);
  begin
    rd(a);
    chk("register", mdl[a], got);
  end
  endtask : rdchk
  task automatic waitIrq(input int n);
    int k;
  begin
    irqCount = 0;
    for (k = 0; k < 2000 && irqCount < n; k++)
      @(posedge ref_clk);
    chk("irq count", 32'(n), 32'(irqCount));
  end
  endtask : waitIrq
  task automatic report_and_stop();
  begin
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask : report_and_stop
  initial
  begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    r = $urandom(24);
    mdl[`PTB_OFF_PRESCALE] = 32'h0000_0000;
    mdl[`PTB_OFF_DIVDMA] = 32'h0000_0000;
    mdl[CTL] = 32'h0000_0000;
    mdl[32'h5100_0100] = 32'h0000_0000;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pins", 32'h0000_000a,
        {26'h000_0000, hi23, dmaReqLow, out1, cmp0, out0});
    @(posedge ref_clk);
    foreach (mdl[a])
      rdchk(a);
    wr(`PTB_OFF_PRESCALE, {8'h00, 24'($urandom)});
    rdchk(`PTB_OFF_PRESCALE);
    wr(`PTB_OFF_PRESCALE, 32'h0000_0000);
    r = 8 + $urandom_range(24);
    wr(T0, 32'(r));
    wr(T0 + 32'h0000_0004, 32'(r / 2));
    wr(CTL, 32'h0000_0002);
    wr(CTL, 32'h0000_0001);
    rdchk(T0);
    waitIrq(1);
    repeat (100) @(posedge ref_clk);
    chk("one-shot irq", 32'h0000_0001, 32'(irqCount));
    rd(T0 + 32'h0000_0008);
    chk("count", 32'h0000_0000, got);
    chk("halt level", 32'h0000_0001, {31'h0, out0});
    wr(CTL, 32'h0000_000a);
    wr(CTL, 32'h0000_0009);
    waitIrq(3);
    wr(CTL, 32'h0000_0008);
    rd(T0 + 32'h0000_0008);
    obs = got;
    repeat (40) @(posedge ref_clk);
    rd(T0 + 32'h0000_0008);
    chk("held count", obs, got);
    chk("stop level", {31'h0, obs <= 32'(r / 2)}, {31'h0, out0});
    wr(CTL, 32'h0000_000c);
    @(negedge ref_clk);
    chk("inverted", {31'h0, obs > 32'(r / 2)}, {31'h0, out0});
    @(posedge ref_clk);
    wr(CTL, 32'h0000_000a);
    wr(CTL, 32'h0000_0009);
    foreach (codes[i])
    begin
      irqEnable <= (i == 6) ? 5'h1e : 5'h1f;
      ackDelay <= 4'($urandom_range(5));
      wr(`PTB_OFF_DIVDMA, {8'h00, codes[i], 20'h0_0000});
      irqCount = 0;
      a0 = ackCount;
      repeat (8 * r + 40) @(posedge ref_clk);
      chk("irq", 32'(codes[i] != 4'h1 && i != 6), 32'(irqCount > 0));
      chk("dma", 32'(codes[i] == 4'h1), 32'(ackCount > a0));
    end
    wr(`PTB_OFF_PRESCALE, 32'h0003_0000);
    wr(CTL, 32'h0000_001a);
    wr(CTL, 32'h0000_0019);
    both = 0;
    rise = 0;
    repeat (8 * r + 40) @(posedge ref_clk);
    chk("overlap", 32'h0000_0000, 32'(both));
    chk("toggling", 32'h0000_0001, 32'(rise > 1));
    report_and_stop();
  end
endmodule : ptb_timer_bank_tb_top
